// ---- pkg/stn_defines.vh ----
`ifndef STN_DEFINES_VH
`define STN_DEFINES_VH

// Colour panel formats
`define STN_MODE_C4 2'h0
`define STN_MODE_C8F1 2'h1
`define STN_MODE_C8F2 2'h2
`define STN_MODE_C16 2'h3

// Panel type selecting passive timing
`define STN_PANEL_PASSIVE 2'h0

// Field decode offsets, in pixels
`define STN_FIELD_ONE 12'h001
`define STN_HORIZONTAL_DISPLAY_START_ADD 12'h016
`define STN_UNIT_SHIFT 3

// Fixed positions, in half pixels
`define STN_AC_TOGGLE_H2 12'h002
`define STN_C4_START_ADD 12'h002

// Colour 16-bit pattern over 32 half pixels: loads and high phases
`define STN_C16_LOAD_A 5'h00
`define STN_C16_LOAD_B 5'h0a
`define STN_C16_LOAD_C 5'h14
`define STN_C16_HIGH_LEN 5'h04
`define STN_C16_HIGH_LAG 5'h04

// Colour 8-bit format 1 phases within 8 half pixels
`define STN_F1_SEC_LO 3'h2
`define STN_F1_SEC_HI 3'h6

`endif

// ---- verilog/stn_timing_gen.v ----
// Operation
// - Display lasts vertical display field plus one lines.
// - Remaining lines up to vertical total are blank lines.
// - Horizontal display is (field plus one) times eight pixel clocks.
// - Horizontal total is (field plus one) times eight; blank is the rest.
// - Frame pulse set up and held around line pulse falling edge.
// - Line pulse repeats every horizontal total, lasting programmed width.
// - AC-bias toggle changes at least start minus one before line pulse.
// - First shift rising edge at display start; plus one pixel in 4-bit, plus two pixels in 16-bit.
// - First shift fall half pixel after rise in 4-bit mode.
// - Last shift fall ends the display window before line pulse.
// - 4-bit mode: one-pixel shift period, data on upper lines.
// - 8-bit format 1: two shift clocks, four-pixel period, two-pixel phases.
// - 8-bit format 1: data valid one pixel around either falling edge.
// - Format 1 main rise and second fall three pixels after start.
// - 8-bit format 2: two-pixel shift period, data one pixel around fall.
// - 16-bit mode: sixteen pixels per three shift rising edges.
// - 16-bit mode: data set up and held around rising edge.
// - Line pulse start is field plus one pixel.
// - Line pulse width is field plus one pixel.
// - Display start is field plus 22 pixels.
// - Timing runs only with panel type passive.
`timescale 1ns/1ps
`include "stn_defines.vh"
`default_nettype none

module stn_timing_gen #(
  parameter DW = 16,
  parameter DEPTH = 2
) (
  // Clock, reset, enable
  input wire clock,
  input wire rst_n,
  input wire clk_en,
  // Pixel clock from outside
  input wire pixel_clock_pin,
  // Configuration
  input wire [1:0] panel_type,
  input wire [1:0] color_mode,
  input wire [6:0] horizontal_total,
  input wire [6:0] horizontal_display_period,
  input wire [9:0] horizontal_display_start,
  input wire [9:0] line_pulse_start,
  input wire [6:0] line_pulse_width,
  input wire [9:0] vertical_total,
  input wire [9:0] vertical_display_period,
  input wire [5:0] ac_bias_lines,
  // Pixel data stream
  input wire pix_valid,
  output wire pix_ready,
  input wire [DW-1:0] pix_data,
  // Status
  output reg data_underrun,
  // Panel pins
  output reg frame_pulse,
  output reg line_pulse,
  output reg shift_clock,
  output reg second_shift_clock,
  output reg ac_bias_toggle,
  output reg [15:0] panel_data_bus
);

  ////////////////////////////////////////////////////////////////
  // Helpers

  // Distance from b forward to a, modulo m
  function [11:0] wrapd;
    input [11:0] a;
    input [11:0] b;
    input [11:0] m;
    reg [12:0] t;
    begin
      t = {1'b0, a} + {1'b0, m} - {1'b0, b};
      if (t >= {1'b0, m})
        t = t - {1'b0, m};
      wrapd = t[11:0];
    end
  endfunction

  // Field plus one, in half pixels
  function [11:0] half_px;
    input [9:0] f;
    begin
      half_px = ({2'h0, f} + `STN_FIELD_ONE) << 1;
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Pixel clock sampling

  reg pclk_s1;
  reg pclk_s2;
  reg pclk_s3;
  reg fresh;
  wire tick = pclk_s2 ^ pclk_s3;
  wire run = clk_en && (panel_type == `STN_PANEL_PASSIVE);

  always @(posedge clock) begin
    if (!rst_n) begin
      pclk_s1 <= 1'b0;
      pclk_s2 <= 1'b0;
      pclk_s3 <= 1'b0;
      fresh <= 1'b0;
    end else if (clk_en) begin
      pclk_s1 <= pixel_clock_pin;
      pclk_s2 <= pclk_s1;
      pclk_s3 <= pclk_s2;
      fresh <= tick && run;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Field decode, all in half pixels (both pixel clock edges)

  wire [11:0] ht2 = ({5'h00, horizontal_total} + `STN_FIELD_ONE) << (`STN_UNIT_SHIFT + 1);
  wire [11:0] hdp2 = ({5'h00, horizontal_display_period} + `STN_FIELD_ONE)
                     << (`STN_UNIT_SHIFT + 1);
  wire [11:0] hds2 = ({2'h0, horizontal_display_start} + `STN_HORIZONTAL_DISPLAY_START_ADD) << 1;
  wire [11:0] lps2 = half_px(line_pulse_start);
  wire [11:0] lpw2 = half_px({3'h0, line_pulse_width});
  wire [11:0] win_start = (color_mode == `STN_MODE_C4) ? hds2 + `STN_C4_START_ADD : hds2;

  ////////////////////////////////////////////////////////////////
  // Counters

  reg [11:0] hcnt;
  reg [9:0] vcnt;
  reg [5:0] ac_cnt;
  wire line_end = (hcnt == ht2 - 12'h001);

  always @(posedge clock) begin
    if (!rst_n) begin
      hcnt <= 12'h000;
      vcnt <= 10'h000;
    end else if (run && tick) begin
      if (line_end || hcnt >= ht2) begin
        hcnt <= 12'h000;
        if (vcnt >= vertical_total)
          vcnt <= 10'h000;
        else
          vcnt <= vcnt + 10'h001;
      end else begin
        hcnt <= hcnt + 12'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Shift and load phases

  wire [11:0] pos = wrapd(hcnt, win_start, ht2);
  wire [11:0] lp_rel = wrapd(hcnt, lps2, ht2);
  wire vdisp = (vcnt <= vertical_display_period);
  wire in_win = vdisp && (pos < hdp2);
  wire [4:0] q16 = pos[4:0];
  wire [2:0] m8 = pos[2:0];

  reg next_shift;
  reg next_shift2;
  reg load_phase;

  always @* begin
    next_shift = 1'b0;
    next_shift2 = 1'b0;
    load_phase = 1'b0;
    case (color_mode)
      `STN_MODE_C4: begin
        next_shift = ~pos[0];
        load_phase = ~pos[0];
      end
      `STN_MODE_C8F1: begin
        // two clocks, second falls as main rises
        next_shift2 = (m8 >= `STN_F1_SEC_LO) && (m8 < `STN_F1_SEC_HI);
        next_shift = (m8 >= `STN_F1_SEC_HI) || (m8 < `STN_F1_SEC_LO);
        // load one pixel before each fall
        load_phase = (pos[1:0] == 2'h0);
      end
      `STN_MODE_C8F2: begin
        next_shift = ~pos[1];
        load_phase = (pos[1:0] == 2'h0);
      end
      default: begin
        next_shift = ((q16 >= `STN_C16_LOAD_A + `STN_C16_HIGH_LAG) &&
                      (q16 < `STN_C16_LOAD_A + `STN_C16_HIGH_LAG + `STN_C16_HIGH_LEN)) ||
                     ((q16 >= `STN_C16_LOAD_B + `STN_C16_HIGH_LAG) &&
                      (q16 < `STN_C16_LOAD_B + `STN_C16_HIGH_LAG + `STN_C16_HIGH_LEN)) ||
                     ((q16 >= `STN_C16_LOAD_C + `STN_C16_HIGH_LAG) &&
                      (q16 < `STN_C16_LOAD_C + `STN_C16_HIGH_LAG + `STN_C16_HIGH_LEN));
        // data loaded two pixels before each rise
        load_phase = (q16 == `STN_C16_LOAD_A) || (q16 == `STN_C16_LOAD_B) ||
                     (q16 == `STN_C16_LOAD_C);
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Two-entry buffer; drained only at load phases, so it really fills

  reg [DW-1:0] mem [0:DEPTH-1];
  reg [1:0] fcount;
  reg wptr;
  reg rptr;
  wire full = (fcount == DEPTH);
  wire empty = (fcount == 2'h0);
  wire want = fresh && in_win && load_phase;
  wire pop = want && !empty;
  wire push = pix_valid && !full;
  assign pix_ready = !full;

  always @(posedge clock) begin
    if (!rst_n) begin
      fcount <= 2'h0;
      wptr <= 1'b0;
      rptr <= 1'b0;
    end else if (clk_en) begin
      if (push) begin
        mem[wptr] <= pix_data;
        wptr <= ~wptr;
      end
      if (pop)
        rptr <= ~rptr;
      if (push && !pop)
        fcount <= fcount + 2'h1;
      else if (pop && !push)
        fcount <= fcount - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Panel outputs

  wire frame_start = fresh && (hcnt == 12'h000) && (vcnt == 10'h000);
  wire ac_point = fresh && (hcnt == `STN_AC_TOGGLE_H2);

  always @(posedge clock) begin
    if (!rst_n) begin
      frame_pulse <= 1'b0;
      line_pulse <= 1'b0;
      shift_clock <= 1'b0;
      second_shift_clock <= 1'b0;
      ac_bias_toggle <= 1'b0;
      ac_cnt <= 6'h00;
      panel_data_bus <= 16'h0000;
      data_underrun <= 1'b0;
    end else if (clk_en && !run) begin
      // Panel pins except ac_bias_toggle idle low while not a passive panel
      frame_pulse <= 1'b0;
      line_pulse <= 1'b0;
      shift_clock <= 1'b0;
      second_shift_clock <= 1'b0;
      panel_data_bus <= 16'h0000;
    end else if (clk_en) begin
      // whole first line, around line pulse fall
      frame_pulse <= (vcnt == 10'h000);
      line_pulse <= (lp_rel < lpw2);
      shift_clock <= in_win && next_shift;
      second_shift_clock <= in_win && next_shift2;
      // toggle one pixel into the line
      if (ac_point && (hcnt == `STN_AC_TOGGLE_H2)) begin
        if (ac_bias_lines == 6'h00) begin
          if (vcnt == 10'h000)
            ac_bias_toggle <= ~ac_bias_toggle;
        end else if (ac_cnt >= ac_bias_lines - 6'h01) begin
          ac_cnt <= 6'h00;
          ac_bias_toggle <= ~ac_bias_toggle;
        end else begin
          ac_cnt <= ac_cnt + 6'h01;
        end
      end
      if (pop) begin
        case (color_mode)
          `STN_MODE_C4: panel_data_bus <= {8'h00, mem[rptr][3:0], 4'h0};
          `STN_MODE_C8F1: panel_data_bus <= {8'h00, mem[rptr][7:0]};
          `STN_MODE_C8F2: panel_data_bus <= {8'h00, mem[rptr][7:0]};
          default: panel_data_bus <= mem[rptr][15:0];
        endcase
      end
      // Underrun holds last data; sticky until the next frame
      if (want && empty)
        data_underrun <= 1'b1;
      else if (frame_start)
        data_underrun <= 1'b0;
    end
  end

endmodule // stn_timing_gen

`default_nettype wire

// ---- test/stn_tg_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module stn_tg_properties (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Controls
  input wire logic clk_en,
  input wire logic [1:0] panel_type,
  input wire logic [1:0] color_mode,
  // Panel pins
  input wire logic frame_pulse,
  input wire logic line_pulse,
  input wire logic shift_clock,
  input wire logic second_shift_clock,
  input wire logic ac_bias_toggle
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n || !clk_en || panel_type != 2'h0);
  ////////////////////////////////////////////////////////////////
  // Outputs refresh on every enabled clock, so six clocks of settling is ample
  a_idle_low: assert property (disable iff (!rst_n)
    (clk_en && panel_type != 2'h0)[*6] |-> !line_pulse && !frame_pulse && !shift_clock)
    else $error("panel pins active while not passive");
  a_second_idle: assert property ((color_mode != 2'h1)[*6] |-> !second_shift_clock)
    else $error("second shift clock outside format 1");
  a_c4_half: assert property (
    color_mode == 2'h0 && $rose(shift_clock) |-> shift_clock[*4] ##1 !shift_clock)
    else $error("colour 4-bit shift phase wrong");
  a_f2_pixel: assert property (
    color_mode == 2'h2 && $rose(shift_clock) |-> shift_clock[*8] ##1 !shift_clock)
    else $error("format 2 shift phase wrong");
  a_f1_handover: assert property (
    color_mode == 2'h1 && $fell(second_shift_clock) |-> $rose(shift_clock))
    else $error("format 1 clocks out of step");
  a_frame_edge: assert property ($changed(frame_pulse) |-> !line_pulse)
    else $error("frame pulse moved during line pulse");
  a_ac_quiet: assert property ($changed(ac_bias_toggle) |-> !line_pulse)
    else $error("ac bias toggled during line pulse");
  a_line_width: assert property ($rose(line_pulse) |-> line_pulse[*8])
    else $error("line pulse shorter than one pixel");
  c_frame: cover property ($rose(frame_pulse));
  c_wide: cover property (color_mode == 2'h3 && $rose(shift_clock));
  c_second: cover property ($rose(second_shift_clock));
endmodule // stn_tg_properties

bind stn_timing_gen stn_tg_properties i_stn_tg_properties (.clock, .rst_n, .clk_en, .panel_type,
  .color_mode, .frame_pulse, .line_pulse, .shift_clock, .second_shift_clock, .ac_bias_toggle);
`default_nettype wire

// ---- test/stn_panel_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module stn_panel_model (
  // Clock
  input wire logic clock,
  // Panel pins
  input wire logic frame_pulse,
  input wire logic line_pulse,
  input wire logic shift_clock,
  input wire logic second_shift_clock,
  // Count the second clock in format 1
  input wire logic use_second,
  // Measurements
  output var logic [15:0] shift_count,
  output var logic [15:0] line_period,
  output var logic [15:0] line_width,
  output var logic [15:0] line_total,
  output var logic [15:0] disp_lines
);
  logic fp, lp, sc;
  logic [15:0] nsh, nl, act, per, wid;
  wire logic sel = use_second ? second_shift_clock : shift_clock;
  ////////////////////////////////////////////////////////////////
  // The panel only sees edges, so counting them per line is its view
  always @(posedge clock) begin
    fp <= frame_pulse;
    lp <= line_pulse;
    sc <= sel;
    per <= per + 16'h0001;
    wid <= line_pulse ? wid + 16'h0001 : 16'h0000;
    if (sel && !sc)
      nsh <= nsh + 16'h0001;
    if (line_pulse && !lp) begin
      line_period <= per;
      per <= 16'h0001;
      nl <= nl + 16'h0001;
      nsh <= 16'h0000;
      if (nsh != 16'h0000) begin
        shift_count <= nsh;
        act <= act + 16'h0001;
      end
    end
    if (!line_pulse && lp)
      line_width <= wid;
    if (frame_pulse && !fp) begin
      line_total <= nl;
      disp_lines <= act;
      nl <= 16'h0000;
      act <= 16'h0000;
    end
  end
endmodule // stn_panel_model
`default_nettype wire

// ---- test/stn_timing_gen_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module stn_timing_gen_tb;
  logic clock = 0, rst_n = 0, clk_en = 1, pclk = 0, pix_valid = 0;
  logic [1:0] panel_type = 2'h1, color_mode = 2'h0;
  logic [6:0] f_disp = 7'h03, f_lwidth = 7'h02, f_total = 7'h07;
  logic a0;
  wire ac_bias_toggle, data_underrun;
  wire [15:0] panel_data_bus;
  logic [9:0] f_start = 10'h000, f_lstart = 10'h03a, f_vtotal = 10'h002, f_vdisp = 10'h000;
  logic [5:0] ac_lines = 6'h00;
  logic [15:0] pix_data = 16'h0000;
  wire pix_ready, frame_pulse, line_pulse, shift_clock, second_shift_clock;
  wire [15:0] n_shift, n_period, n_width, n_lines, n_disp;
  int err_count = 0, checks_done = 0;
  stn_timing_gen i_stn_timing_gen (.clock, .rst_n, .clk_en, .pixel_clock_pin(pclk),
    .panel_type, .color_mode, .horizontal_total(f_total), .horizontal_display_period(f_disp),
    .horizontal_display_start(f_start), .line_pulse_start(f_lstart),
    .line_pulse_width(f_lwidth), .vertical_total(f_vtotal), .vertical_display_period(f_vdisp),
    .ac_bias_lines(ac_lines), .pix_valid, .pix_ready, .pix_data, .data_underrun,
    .frame_pulse, .line_pulse, .shift_clock, .second_shift_clock, .ac_bias_toggle,
    .panel_data_bus);
  stn_panel_model i_stn_panel_model (.clock, .frame_pulse, .line_pulse, .shift_clock,
    .second_shift_clock, .use_second(color_mode == 2'h1), .shift_count(n_shift),
    .line_period(n_period), .line_width(n_width), .line_total(n_lines), .disp_lines(n_disp));
  ////////////////////////////////////////////////////////////////
  initial forever #50 clock = ~clock;
  // Odd offset keeps pixel edges away from system clock edges
  initial begin
    #37;
    forever #400 pclk = ~pclk;
  end
  always @(posedge clock)
    if (pix_valid && pix_ready) pix_data <= 16'($urandom);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [15:0] exp_shift(input logic [1:0] m);
    logic [15:0] px;
    px = 16'((f_disp + 7'h01) * 8);
    case (m)
      2'h0: exp_shift = px;
      2'h1: exp_shift = px / 4;
      2'h2: exp_shift = px / 2;
      default: exp_shift = px * 3 / 16;
    endcase
  endfunction
  initial begin
    #8000000;
    err_count++;
    stop_test();
  end
  initial begin
    void'($urandom(29523));
    repeat (6) @(posedge clock);
    @(negedge clock);
    rst_n = 1;
    clk_en = 0;
    pix_valid = 1;
    repeat (3) @(negedge clock);
    check({15'h0, pix_ready}, 16'h0001);
    clk_en = 1;
    repeat (3) @(negedge clock);
    check({15'h0, pix_ready}, 16'h0000);
    // First pass keeps the widest line pulse of the random range, three pixels
    for (int m = 0; m < 4; m++) begin
      @(negedge clock);
      color_mode = m[1:0];
      f_total = 7'(7 + m % 2);
      f_start = 10'($urandom % 4);
      f_lstart = 10'(58 + $urandom % 2);
      if (m > 0) f_lwidth = 7'($urandom % 3);
      f_vtotal = 10'(2 + $urandom % 3);
      f_vdisp = 10'($urandom % f_vtotal);
      ac_lines = (m == 0) ? 6'h00 : 6'($urandom % 4);
      panel_type = 2'h0;
      repeat (2) @(posedge frame_pulse);
      @(negedge clock);
      a0 = ac_bias_toggle;
      @(posedge frame_pulse);
      repeat (2) @(negedge clock);
      if (ac_lines == 6'h00) check({15'h0, ac_bias_toggle}, {15'h0, ~a0});
      check({15'h0, data_underrun}, 16'h0000);
      if (m < 3) check({8'h00, panel_data_bus[15:8]}, 16'h0000);
      if (m == 0) check({12'h000, panel_data_bus[3:0]}, 16'h0000);
      check(n_lines, 16'(f_vtotal + 10'h001));
      check(n_disp, 16'(f_vdisp + 10'h001));
      check(n_period, 16'((f_total + 7'h01) * 64));
      check(n_width, 16'((f_lwidth + 7'h01) * 8));
      check(n_shift, exp_shift(m[1:0]));
      panel_type = 2'h1;
      repeat (8) @(negedge clock);
      check({12'h0, frame_pulse, line_pulse, shift_clock, second_shift_clock}, 16'h0);
    end
    stop_test();
  end
endmodule // stn_timing_gen_tb
`default_nettype wire
